//--- dv/tb.sv
`include "ubirq_regs.svh"
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   ref_clk;
  logic                   srst;
  logic [3:0]             avs_address;
  logic                   avs_read;
  logic                   avs_write;
  logic [31:0]            avs_writedata;
  logic [3:0]             avs_byteenable;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  ubirq_pkg::ubirq_evt_t  evt;
  logic                   pwr;
  ubirq_pkg::ubirq_ctrl_t ctrl;
  logic                   irq;
  int                     n_errors;
  int                     n_tests;
  logic [31:0]            rd;

  ubirq_top dut (
    .ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .evt(evt), .usb_power_sense_input(pwr),
    .dma_master_setup(ctrl), .irq(irq));

  ubirq_far_model far (
    .ref_clk(ref_clk), .evt(evt), .usb_power_sense_input(pwr),
    .dma_master_setup(ctrl));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Holds the request until waitrequest is sampled low at an edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd, input logic [3:0] be,
                     output logic [31:0] q);
    int i;
    @(posedge ref_clk);
    avs_address    <= a;
    avs_writedata  <= wd;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= !wr;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      n_errors++;
      tally_and_finish();
    end else begin
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask

  task automatic wr_be(input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask

  task automatic wr32(input logic [3:0] a, input logic [31:0] d);
    wr_be(a, d, 4'hF);
  endtask

  task automatic rd_chk(input string nm, input logic [3:0] a,
                        input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hF, q);
    chk(nm, exp, q);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic t_reset_map();
    rd_chk("status", `UBIRQ_STS_OFFS, `UBIRQ_STS_RST);
    rd_chk("mask", `UBIRQ_MASK_OFFS, `UBIRQ_MASK_RST);
    rd_chk("ctrl", `UBIRQ_CTRL_OFFS, 32'h0000_0000);
    wr32(4'hC, 32'hFFFF_FFFF);
    rd_chk("unmapped", 4'hC, 32'h0000_0000);
    wr32(`UBIRQ_MASK_OFFS, 32'hFFFF_FFFF);
    rd_chk("mask_spare", `UBIRQ_MASK_OFFS, `UBIRQ_STS_IMPL);
    wr32(`UBIRQ_MASK_OFFS, 32'h0000_0000);
    $display("test reset_map done");
  endtask

  // Each row: lead-in level, event level, status bits it must leave
  task automatic t_events();
    logic [9:0]  pre [10] = '{10'h000, 10'h000, 10'h000, 10'h000, 10'h000,
                             10'h008, 10'h004, 10'h000, 10'h000, 10'h001};
    logic [9:0]  ev  [10] = '{10'h200, 10'h300, 10'h080, 10'h040, 10'h020,
                             10'h018, 10'h014, 10'h010, 10'h002, 10'h000};
    logic [31:0] exp [10] = '{32'h2000_0000, 32'h0000_0000, 32'h0200_0000,
                             32'h0100_0000, 32'h0100_0000, 32'h0080_0000,
                             32'h0010_0000, 32'h0000_0000, 32'h0020_0000,
                             32'h0040_0000};
    for (int k = 0; k < 10; k++) begin
      far.drive(pre[k]);
      idle(2);
      far.drive(ev[k]);
      idle(2);
      far.drive(10'h000);
      idle(3);
      if (k < 5) begin
        rd_chk("evt_lo", `UBIRQ_STS_OFFS, exp[k]);
      end else begin
        rd_chk("evt_hi", `UBIRQ_STS_OFFS, exp[k]);
      end
      wr32(`UBIRQ_STS_OFFS, 32'hFFFF_FFFF);
      rd_chk("evt_clear", `UBIRQ_STS_OFFS, 32'h0000_0000);
    end
    for (int k = 0; k < 2; k++) begin
      far.toggle_power();
      idle(3);
      rd_chk("power", `UBIRQ_STS_OFFS, 32'h1000_0000);
      wr32(`UBIRQ_STS_OFFS, 32'h1000_0000);
    end
    $display("test events done");
  endtask

  task automatic t_irq_sticky();
    int i;
    wr32(`UBIRQ_MASK_OFFS, 32'h0020_0000);
    far.drive(10'h040);
    far.drive(10'h000);
    idle(5);
    chk("irq_masked", 32'h0, {31'h0, irq});
    far.drive(10'h002);
    far.drive(10'h000);
    for (i = 0; i < 8 && irq !== 1'b1; i++) @(posedge ref_clk);
    chk("irq_rise", 32'h1, {31'h0, irq});
    idle(10);
    rd_chk("sticky", `UBIRQ_STS_OFFS, 32'h0120_0000);
    wr32(`UBIRQ_STS_OFFS, 32'h0020_0000);
    idle(3);
    chk("irq_fall", 32'h0, {31'h0, irq});
    rd_chk("partial_clr", `UBIRQ_STS_OFFS, 32'h0100_0000);
    wr32(`UBIRQ_STS_OFFS, 32'hFFFF_FFFF);
    wr32(`UBIRQ_MASK_OFFS, 32'h0000_0000);
    $display("test irq_sticky done");
  endtask

  task automatic t_bus_error();
    far.drive(10'h00C);
    idle(2);
    far.drive(10'h01C);
    far.drive(10'h00C);
    idle(3);
    rd_chk("both_err", `UBIRQ_STS_OFFS, 32'h0090_0000);
    wr32(`UBIRQ_CTRL_OFFS, 32'h0000_0003);
    idle(2);
    chk("blk_rst", 32'h3, {30'h0, ctrl});
    rd_chk("ctrl_rb", `UBIRQ_CTRL_OFFS, 32'h0000_0003);
    wr32(`UBIRQ_CTRL_OFFS, 32'h0000_0000);
    wr32(`UBIRQ_STS_OFFS, 32'hFFFF_FFFF);
    rd_chk("err_clr", `UBIRQ_STS_OFFS, 32'h0000_0000);
    $display("test bus_error done");
  endtask

  // Partial writes: status and mask honour every lane, control lane 0 only
  task automatic t_byte_lanes();
    far.drive(10'h042);
    far.drive(10'h000);
    idle(3);
    wr_be(`UBIRQ_STS_OFFS, 32'hFFFF_FFFF, 4'h4);
    rd_chk("be_lane2", `UBIRQ_STS_OFFS, 32'h0100_0000);
    wr_be(`UBIRQ_STS_OFFS, 32'hFFFF_FFFF, 4'h8);
    rd_chk("be_lane3", `UBIRQ_STS_OFFS, 32'h0000_0000);
    wr_be(`UBIRQ_MASK_OFFS, 32'hFFFF_FFFF, 4'h8);
    rd_chk("be_mask", `UBIRQ_MASK_OFFS, 32'h3300_0000);
    wr_be(`UBIRQ_CTRL_OFFS, 32'h0000_0003, 4'hE);
    rd_chk("be_ctrl", `UBIRQ_CTRL_OFFS, 32'h0000_0000);
    wr32(`UBIRQ_MASK_OFFS, 32'h0000_0000);
    $display("test byte_lanes done");
  endtask

  // A reset in mid-run must drop flags, mask, controls and the interrupt
  task automatic t_mid_reset();
    wr32(`UBIRQ_MASK_OFFS, 32'h0100_0000);
    wr32(`UBIRQ_CTRL_OFFS, 32'h0000_0003);
    far.drive(10'h040);
    far.drive(10'h000);
    idle(3);
    chk("irq_pre", 32'h1, {31'h0, irq});
    @(posedge ref_clk);
    srst <= 1'b1;
    idle(3);
    srst <= 1'b0;
    @(posedge ref_clk);
    chk("rst_irq", 32'h0, {31'h0, irq});
    chk("rst_ctrl", 32'h0, {30'h0, ctrl});
    chk("rst_wait", 32'h1, {31'h0, avs_waitrequest});
    chk("rst_rdata", 32'h0, avs_readdata);
    idle(1);
    rd_chk("rst_sts", `UBIRQ_STS_OFFS, `UBIRQ_STS_RST);
    rd_chk("rst_mask", `UBIRQ_MASK_OFFS, `UBIRQ_MASK_RST);
    $display("test mid_reset done");
  endtask

  initial begin
    n_errors = 0;
    n_tests = 0;
    srst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    idle(2);
    t_reset_map();
    t_events();
    t_irq_sticky();
    t_bus_error();
    t_byte_lanes();
    t_mid_reset();
    tally_and_finish();
  end
endmodule // tb

`default_nettype wire

//--- dv/ubirq_far_model.sv
`default_nettype none

module ubirq_far_model (
  // Clock
  input  wire logic                   ref_clk,
  // Events toward the bridge
  output var ubirq_pkg::ubirq_evt_t   evt,
  output var logic                    usb_power_sense_input,
  // DMA block resets from the bridge
  input  wire ubirq_pkg::ubirq_ctrl_t dma_master_setup
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    evt = '0;
    usb_power_sense_input = 1'b0;
  end

  // Levels change only just after an edge, like the real engines
  task automatic drive(input logic [9:0] v);
    @(posedge ref_clk);
    evt <= ubirq_pkg::ubirq_evt_t'(v);
  endtask

  task automatic toggle_power();
    @(posedge ref_clk);
    usb_power_sense_input <= !usb_power_sense_input;
  endtask

  // A block reset from software drops that engine's active level
  always @(posedge ref_clk) begin
    if (dma_master_setup.rd_dma_block_reset) begin
      evt.rd_dma_active <= 1'b0;
    end
    if (dma_master_setup.wr_dma_block_reset) begin
      evt.wr_dma_active <= 1'b0;
    end
  end
endmodule // ubirq_far_model

`default_nettype wire

//--- hdl/ubirq_edge.sv
`default_nettype none

module ubirq_edge #(
  parameter bit ANY_CHANGE = 1'b1
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // Level in, event out
  input  wire logic level,
  output logic      hit
);

  logic prev_r;
  logic primed_r;

  // No event in the first cycle after reset: the previous level is unknown
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prev_r   <= 1'b0;
      primed_r <= 1'b0;
    end else begin
      prev_r   <= level;
      primed_r <= 1'b1;
    end
  end

  assign hit = primed_r &&
               (ANY_CHANGE ? (level != prev_r) : (prev_r && !level));

endmodule // ubirq_edge

`default_nettype wire

//--- hdl/ubirq_flags.sv
`default_nettype none

module ubirq_flags #(
  parameter int unsigned W = 32
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         srst,
  // Set and clear strobes
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // Sticky flags
  output logic [W-1:0]      flags
);

  logic [W-1:0] flags_r;
  logic [W-1:0] flags_nxt;

  for (genvar i = 0; i < W; i++) begin : g_bit
    // Set wins over a clear in the same cycle so no event is lost
    assign flags_nxt[i] = set[i] | (flags_r[i] & ~clr[i]); // see [R12]

    sticky_hold_a : // see [R12]
    assert property (@(posedge ref_clk) disable iff (srst)
      flags_r[i] && !clr[i] |=> flags_r[i])
      else $error("sticky flag dropped without clear");

    set_wins_a : // see [R12]
    assert property (@(posedge ref_clk) disable iff (srst)
      set[i] && clr[i] |=> flags_r[i])
      else $error("clear beat a simultaneous set");
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;

endmodule // ubirq_flags

`default_nettype wire

//--- hdl/ubirq_pkg.sv
`default_nettype none

package ubirq_pkg;

  // --------------------------------------------------------------------------
  // Events from the device core and the DMA engines
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic wr_ep_access;
    logic wr_ep_bus_sel;
    logic bridge_rd_done;
    logic core_rd_done;
    logic core_wr_done;
    logic ahb_error;
    logic rd_dma_active;
    logic wr_dma_active;
    logic rd_dma_done;
    logic rd_fifo_full;
  } ubirq_evt_t;

  // --------------------------------------------------------------------------
  // DMA block reset controls
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic wr_dma_block_reset;
    logic rd_dma_block_reset;
  } ubirq_ctrl_t;

  typedef enum logic {
    ST_IDLE,
    ST_ACK
  } ubirq_bus_st_t;

endpackage

`default_nettype wire

//--- hdl/ubirq_regs.svh
`ifndef UBIRQ_REGS_SVH
`define UBIRQ_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define UBIRQ_ADDR_W        4
`define UBIRQ_STS_OFFS      4'h0
`define UBIRQ_MASK_OFFS     4'h4
`define UBIRQ_CTRL_OFFS     4'h8

// ----------------------------------------------------------------------------
// Status and mask field positions
// ----------------------------------------------------------------------------
`define UBIRQ_BIT_WR_EP_ERR 29
`define UBIRQ_BIT_POWER     28
`define UBIRQ_BIT_BRG_RD    25
`define UBIRQ_BIT_CORE_ACC  24
`define UBIRQ_BIT_RD_BUSERR 23
`define UBIRQ_BIT_RD_FIFO   22
`define UBIRQ_BIT_RD_DONE   21
`define UBIRQ_BIT_WR_BUSERR 20
`define UBIRQ_STS_IMPL      32'h33F0_0000

// ----------------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------------
`define UBIRQ_BIT_RD_RST    0
`define UBIRQ_BIT_WR_RST    1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define UBIRQ_STS_RST       32'h0000_0000
`define UBIRQ_MASK_RST      32'h0000_0000
`define UBIRQ_CTRL_RST      2'h0

`endif

//--- hdl/ubirq_top.sv
// Operation
// [R1] Write DMA on common-bus endpoint sets bit 29
// [R2] Power sense level change sets bit 28
// [R3] Bridge indirect read completion sets bit 25
// [R4] Core register read completion sets bit 24
// [R5] Core register write completion sets bit 24
// [R6] Bus error during read DMA sets bit 23
// [R7] Software resets read DMA after bus error
// [R8] Read DMA FIFO becoming not full sets 22
// [R9] Read DMA completion sets bit 21
// [R10] Bus error during write DMA sets bit 20
// [R11] Software resets write DMA after bus error
// [R12] Flags sticky until software clear; spare bits
`include "ubirq_regs.svh"
`default_nettype none

module ubirq_top (
  // Clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           srst,
  // Avalon-MM slave
  input  wire logic [`UBIRQ_ADDR_W-1:0]       avs_address,
  input  wire logic                           avs_read,
  input  wire logic                           avs_write,
  input  wire logic [31:0]                    avs_writedata,
  input  wire logic [3:0]                     avs_byteenable,
  output logic [31:0]                         avs_readdata,
  output logic                                avs_waitrequest,
  // Bridge events
  input  wire ubirq_pkg::ubirq_evt_t          evt,
  input  wire logic                           usb_power_sense_input,
  // DMA block controls and interrupt
  output ubirq_pkg::ubirq_ctrl_t              dma_master_setup,
  output logic                                irq
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  ubirq_pkg::ubirq_bus_st_t state_r;
  logic                     wait_r;
  logic [31:0]              rdata_r;
  logic [31:0]              mask_r;
  ubirq_pkg::ubirq_ctrl_t   ctrl_r;
  logic                     irq_r;

  logic [31:0]              sts;
  logic [31:0]              sts_set;
  logic [31:0]              sts_clr;
  logic [31:0]              be_mask;
  logic [31:0]              rd_mux;
  logic                     wr_commit;
  logic                     pwr_change;
  logic                     fifo_ready;

  // --------------------------------------------------------------------------
  // Event edge detection
  // --------------------------------------------------------------------------
  // Either direction of the power level counts as a change
  ubirq_edge #(
    .ANY_CHANGE (1'b1)
  ) u_pwr_edge (
    .ref_clk (ref_clk),
    .srst    (srst),
    .level   (usb_power_sense_input),
    .hit     (pwr_change)
  );

  // Only the full-to-not-full transition means the FIFO became writable
  ubirq_edge #(
    .ANY_CHANGE (1'b0)
  ) u_fifo_edge (
    .ref_clk (ref_clk),
    .srst    (srst),
    .level   (evt.rd_fifo_full),
    .hit     (fifo_ready)
  );

  // --------------------------------------------------------------------------
  // Status set and clear vectors
  // --------------------------------------------------------------------------
  always_comb begin
    sts_set = '0;
    sts_set[`UBIRQ_BIT_WR_EP_ERR] = evt.wr_ep_access &&
                                    !evt.wr_ep_bus_sel;      // see [R1]
    sts_set[`UBIRQ_BIT_POWER]     = pwr_change;              // see [R2]
    sts_set[`UBIRQ_BIT_BRG_RD]    = evt.bridge_rd_done;      // see [R3]
    sts_set[`UBIRQ_BIT_CORE_ACC]  = evt.core_rd_done ||      // see [R4]
                                    evt.core_wr_done;        // see [R5]
    sts_set[`UBIRQ_BIT_RD_BUSERR] = evt.ahb_error &&
                                    evt.rd_dma_active;       // see [R6]
    sts_set[`UBIRQ_BIT_RD_FIFO]   = fifo_ready;              // see [R8]
    sts_set[`UBIRQ_BIT_RD_DONE]   = evt.rd_dma_done;         // see [R9]
    sts_set[`UBIRQ_BIT_WR_BUSERR] = evt.ahb_error &&
                                    evt.wr_dma_active;       // see [R10]
  end

  // Byte enables widen to a bit mask for partial writes
  always_comb begin
    be_mask = '0;
    for (int b = 0; b < 4; b++) begin
      be_mask[b*8 +: 8] = {8{avs_byteenable[b]}};
    end
  end

  // A write takes effect only at the edge where waitrequest is seen low
  assign wr_commit = (state_r == ubirq_pkg::ST_ACK) && avs_write;

  // Write-one-to-clear, limited to implemented flags
  assign sts_clr = (wr_commit && avs_address == `UBIRQ_STS_OFFS) ?
                   (avs_writedata & be_mask & `UBIRQ_STS_IMPL) : '0;

  // --------------------------------------------------------------------------
  // Sticky status flags
  // --------------------------------------------------------------------------
  ubirq_flags #(
    .W (32)
  ) u_sts (
    .ref_clk (ref_clk),
    .srst    (srst),
    .set     (sts_set),
    .clr     (sts_clr),
    .flags   (sts)
  );

  // --------------------------------------------------------------------------
  // Read multiplexer
  // --------------------------------------------------------------------------
  // Spare status bits read as zero; unmapped offsets read as zero
  always_comb begin
    case (avs_address)
      `UBIRQ_STS_OFFS:  rd_mux = sts & `UBIRQ_STS_IMPL;     // see [R12]
      `UBIRQ_MASK_OFFS: rd_mux = mask_r;
      `UBIRQ_CTRL_OFFS: rd_mux = {30'h0000_0000, ctrl_r};
      default:          rd_mux = '0;
    endcase
  end

  // --------------------------------------------------------------------------
  // Bus handshake
  // --------------------------------------------------------------------------
  // Fixed one-cycle answer: the read value is captured on the edge that
  // takes the request, so it stands stable at the accepting edge.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= ubirq_pkg::ST_IDLE;
      wait_r  <= 1'b1;
      rdata_r <= '0;
    end else begin
      case (state_r)
        ubirq_pkg::ST_IDLE: begin
          if (avs_read || avs_write) begin
            state_r <= ubirq_pkg::ST_ACK;
            wait_r  <= 1'b0;
            rdata_r <= avs_read ? rd_mux : '0;
          end
        end
        ubirq_pkg::ST_ACK: begin
          state_r <= ubirq_pkg::ST_IDLE;
          wait_r  <= 1'b1;
        end
        default: begin
          state_r <= ubirq_pkg::ST_IDLE;
          wait_r  <= 1'b1;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Mask register
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mask_r <= `UBIRQ_MASK_RST;
    end else if (wr_commit && avs_address == `UBIRQ_MASK_OFFS) begin
      mask_r <= ((avs_writedata & be_mask) | (mask_r & ~be_mask)) &
                `UBIRQ_STS_IMPL;
    end
  end

  // --------------------------------------------------------------------------
  // DMA block reset controls
  // --------------------------------------------------------------------------
  // Levels held by software; the DMA blocks stay in reset while set.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_r <= `UBIRQ_CTRL_RST;
    end else if (wr_commit && avs_address == `UBIRQ_CTRL_OFFS &&
                 avs_byteenable[0]) begin
      ctrl_r.rd_dma_block_reset <= avs_writedata[`UBIRQ_BIT_RD_RST]; // see [R7]
      ctrl_r.wr_dma_block_reset <= avs_writedata[`UBIRQ_BIT_WR_RST]; // see [R11]
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt output
  // --------------------------------------------------------------------------
  // Registered for a clean output, at the cost of one cycle of latency
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(sts & mask_r);
    end
  end

  assign avs_readdata     = rdata_r;
  assign avs_waitrequest  = wait_r;
  assign dma_master_setup = ctrl_r;
  assign irq              = irq_r;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  ep_read_err_a : // see [R1]
  assert property (@(posedge ref_clk) disable iff (srst)
    evt.wr_ep_access && !evt.wr_ep_bus_sel |=> sts[`UBIRQ_BIT_WR_EP_ERR])
    else $error("endpoint read error flag not set");

  ep_no_err_a : // see [R1]
  assert property (@(posedge ref_clk) disable iff (srst)
    !sts[`UBIRQ_BIT_WR_EP_ERR] && !(evt.wr_ep_access && !evt.wr_ep_bus_sel)
    |=> !sts[`UBIRQ_BIT_WR_EP_ERR])
    else $error("endpoint read error flag set without cause");

  power_change_a : // see [R2]
  assert property (@(posedge ref_clk) disable iff (srst)
    !$past(srst) && $changed(usb_power_sense_input)
    |=> sts[`UBIRQ_BIT_POWER])
    else $error("power change flag not set");

  bridge_rd_a : // see [R3]
  assert property (@(posedge ref_clk) disable iff (srst)
    evt.bridge_rd_done |=> sts[`UBIRQ_BIT_BRG_RD])
    else $error("bridge read done flag not set");

  core_rd_a : // see [R4]
  assert property (@(posedge ref_clk) disable iff (srst)
    evt.core_rd_done |=> sts[`UBIRQ_BIT_CORE_ACC])
    else $error("core read done flag not set");

  core_wr_a : // see [R5]
  assert property (@(posedge ref_clk) disable iff (srst)
    evt.core_wr_done |=> sts[`UBIRQ_BIT_CORE_ACC])
    else $error("core write done flag not set");

  rd_bus_err_a : // see [R6]
  assert property (@(posedge ref_clk) disable iff (srst)
    evt.ahb_error && evt.rd_dma_active |=> sts[`UBIRQ_BIT_RD_BUSERR])
    else $error("read DMA bus error flag not set");

  fifo_ready_a : // see [R8]
  assert property (@(posedge ref_clk) disable iff (srst)
    !$past(srst) && $fell(evt.rd_fifo_full) |=> sts[`UBIRQ_BIT_RD_FIFO])
    else $error("FIFO ready flag not set");

  rd_done_a : // see [R9]
  assert property (@(posedge ref_clk) disable iff (srst)
    evt.rd_dma_done |=> sts[`UBIRQ_BIT_RD_DONE])
    else $error("read DMA done flag not set");

  wr_bus_err_a : // see [R10]
  assert property (@(posedge ref_clk) disable iff (srst)
    evt.ahb_error && evt.wr_dma_active |=> sts[`UBIRQ_BIT_WR_BUSERR])
    else $error("write DMA bus error flag not set");

  spare_zero_a : // see [R12]
  assert property (@(posedge ref_clk) disable iff (srst)
    !avs_waitrequest && avs_read && avs_address == `UBIRQ_STS_OFFS
    |-> (avs_readdata & ~`UBIRQ_STS_IMPL) == 32'h0000_0000)
    else $error("spare status bits read nonzero");

  w1c_clear_a : // see [R12]
  assert property (@(posedge ref_clk) disable iff (srst)
    wr_commit && avs_address == `UBIRQ_STS_OFFS && avs_byteenable[3] &&
    avs_writedata[`UBIRQ_BIT_POWER] && !pwr_change
    |=> !sts[`UBIRQ_BIT_POWER])
    else $error("write one did not clear power flag");

  irq_follow_a :
  assert property (@(posedge ref_clk) disable iff (srst)
    |(sts & mask_r) |=> irq)
    else $error("interrupt not raised for unmasked flag");

  wait_bound_a :
  assert property (@(posedge ref_clk) disable iff (srst)
    (avs_read || avs_write) && avs_waitrequest |-> ##[0:1] !avs_waitrequest)
    else $error("request not answered within one cycle");

  irq_quiet_a :
  assert property (@(posedge ref_clk) disable iff (srst)
    !(|(sts & mask_r)) |=> !irq)
    else $error("interrupt raised with no unmasked flag");

  wait_once_a :
  assert property (@(posedge ref_clk) disable iff (srst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  power_quiet_a : // see [R2]
  assert property (@(posedge ref_clk) disable iff (srst)
    !sts[`UBIRQ_BIT_POWER] && $stable(usb_power_sense_input)
    |=> !sts[`UBIRQ_BIT_POWER])
    else $error("power flag set without level change");

  fifo_quiet_a : // see [R8]
  assert property (@(posedge ref_clk) disable iff (srst)
    !sts[`UBIRQ_BIT_RD_FIFO] && !$fell(evt.rd_fifo_full)
    |=> !sts[`UBIRQ_BIT_RD_FIFO])
    else $error("FIFO ready flag set while FIFO stayed full");

  brg_quiet_a : // see [R3]
  assert property (@(posedge ref_clk) disable iff (srst)
    !sts[`UBIRQ_BIT_BRG_RD] && !evt.bridge_rd_done
    |=> !sts[`UBIRQ_BIT_BRG_RD])
    else $error("bridge read flag set without completion");

  acc_quiet_a : // see [R4] [R5]
  assert property (@(posedge ref_clk) disable iff (srst)
    !sts[`UBIRQ_BIT_CORE_ACC] && !evt.core_rd_done &&
    !evt.core_wr_done
    |=> !sts[`UBIRQ_BIT_CORE_ACC])
    else $error("core access flag set without completion");

  rd_err_quiet_a : // see [R6]
  assert property (@(posedge ref_clk) disable iff (srst)
    !sts[`UBIRQ_BIT_RD_BUSERR] && !(evt.ahb_error && evt.rd_dma_active)
    |=> !sts[`UBIRQ_BIT_RD_BUSERR])
    else $error("read DMA bus error flag set without cause");

  wr_err_quiet_a : // see [R10]
  assert property (@(posedge ref_clk) disable iff (srst)
    !sts[`UBIRQ_BIT_WR_BUSERR] && !(evt.ahb_error && evt.wr_dma_active)
    |=> !sts[`UBIRQ_BIT_WR_BUSERR])
    else $error("write DMA bus error flag set without cause");

  done_quiet_a : // see [R9]
  assert property (@(posedge ref_clk) disable iff (srst)
    !sts[`UBIRQ_BIT_RD_DONE] && !evt.rd_dma_done
    |=> !sts[`UBIRQ_BIT_RD_DONE])
    else $error("read DMA done flag set without completion");

endmodule // ubirq_top

`default_nettype wire
